/* src/crf_map.svh */
// constants for the core register file and condition flags block
// assumes an 8-bit core datapath on one clock drives the ports of crf_regfile
// Summary of operation
// - eight general registers accessed as whole words or separate upper/lower bytes
// - address outputs always carry a register's full sixteen bit value
// - register seven serves implicitly as stack pointer for calls and exceptions
// - sixteen bit program counter; fetch by word, lowest bit read as zero
// - flag register fully accessible by load, store, and, or, xor operations
// - bit seven masks interrupts, set on exception entry, software writable
// - bits six and four are user storage, never altered by results
// - byte arithmetic sets half-carry on carry or borrow at bit three
// - word add, subtract, compare set half-carry on carry or borrow at bit eleven
// - decimal adjust after add or subtract corrects packed BCD using half-carry
// - negative flag takes the result sign bit
// - zero flag set on zero result, cleared otherwise
// - overflow flag set on arithmetic overflow, cleared otherwise
// - carry flag holds add carry, borrow, shifted bit, bit accumulator
// - branch conditions use only negative, zero, overflow and carry flags
// - flags not affected by an operation stay unchanged
// - reset loads counter from vector word at zero and sets interrupt mask
// - bit operations select bit zero to seven of a byte operand
// - byte operands for arithmetic; word forms for move, add, sub, compare
// - word memory accesses force address bit zero to zero
// - flag push duplicates the byte in both halves; pop uses upper byte
`ifndef CRF_MAP_SVH
`define CRF_MAP_SVH
`define CRF_BIT_IMASK 7
`define CRF_BIT_USER6 6
`define CRF_BIT_HALF 5
`define CRF_BIT_USER4 4
`define CRF_BIT_NEG 3
`define CRF_BIT_ZERO 2
`define CRF_BIT_OVF 1
`define CRF_BIT_CARRY 0
`define CRF_SP_INDEX 3'h7
`define CRF_RESET_VECTOR 16'h0000
`define CRF_FLAGS_RESET 8'h80
`endif

/* src/crf_pkg.sv */
// types shared by the register file block
// assumes crf_map.svh supplies the numeric constants
package crf_pkg;
  // alu operation applied to the flag register
  typedef enum logic [3:0] {
    CRF_OP_NONE = 4'h0, CRF_OP_ADD_B = 4'h1, CRF_OP_ADDX_B = 4'h2, CRF_OP_SUB_B = 4'h3,
    CRF_OP_SUBX_B = 4'h4, CRF_OP_CMP_B = 4'h5, CRF_OP_BYTE_NEGATE = 4'h6, CRF_OP_ADD_W = 4'h7,
    CRF_OP_SUB_W = 4'h8, CRF_OP_CMP_W = 4'h9, CRF_OP_DAA = 4'hA, CRF_OP_DAS = 4'hB,
    CRF_OP_LOGIC_B = 4'hC, CRF_OP_MOVE_W = 4'hD
  } crf_alu_op_t;
  // flag register access command
  typedef enum logic [2:0] {
    CRF_FC_NONE = 3'h0, CRF_FC_LOAD = 3'h1, CRF_FC_AND = 3'h2, CRF_FC_OR = 3'h3,
    CRF_FC_XOR = 3'h4, CRF_FC_POP = 3'h5
  } crf_flag_cmd_t;
  // bit manipulation operation on the carry accumulator
  typedef enum logic [2:0] {
    CRF_BIT_NONE = 3'h0, CRF_BIT_LOAD = 3'h1, CRF_BIT_ILOAD = 3'h2, CRF_BIT_AND = 3'h3,
    CRF_BIT_OR = 3'h4, CRF_BIT_XOR = 3'h5
  } crf_bit_op_t;
  // register file activity, one-hot
  typedef enum logic [2:0] {
    CRF_ST_RESET = 3'b001, CRF_ST_VECTOR = 3'b010, CRF_ST_RUN = 3'b100
  } crf_state_t;
endpackage

/* src/crf_regfile.sv */
// general registers, program counter and condition flags of the core
// assumes the execution datapath on the same clock drives all request ports
// and answers vector_fetch_req with vector_word_valid and the word at address zero
`timescale 1ns/1ps
`include "crf_map.svh"
module crf_regfile (
  input wire logic clk,
  input wire logic rstn,
  // general register write port
  input wire logic reg_wr_en,
  input wire logic [1:0] reg_wr_bytes,
  input wire logic [2:0] reg_wr_index,
  input wire logic [15:0] reg_wr_data,
  // read ports
  input wire logic [2:0] rd_a_index,
  input wire logic [2:0] rd_b_index,
  output logic [15:0] rd_a_word,
  output logic [7:0] rd_a_byte,
  input wire logic rd_a_upper,
  output logic [15:0] rd_b_word,
  output logic [15:0] reg_addr_word,
  output logic [15:0] stack_pointer,
  // program counter
  input wire logic pc_load,
  input wire logic [15:0] pc_load_value,
  input wire logic pc_advance,
  output logic [15:0] pc_value,
  output logic [15:0] fetch_addr,
  input wire logic [15:0] data_addr_in,
  output logic [15:0] word_data_addr,
  // reset vector fetch
  output logic vector_fetch_req,
  input wire logic vector_word_valid,
  input wire logic [15:0] vector_word,
  // flag register access
  input wire crf_pkg::crf_flag_cmd_t flag_cmd,
  input wire logic [15:0] flag_cmd_data,
  output logic [7:0] condition_flag_register,
  output logic [15:0] flag_push_word,
  input wire logic exception_entry,
  output logic interrupt_masked,
  // arithmetic flag update
  input wire crf_pkg::crf_alu_op_t alu_op,
  input wire logic [15:0] alu_a,
  input wire logic [15:0] alu_b,
  output logic [15:0] alu_result,
  // shift carry and bit accumulator
  input wire logic shift_carry_en,
  input wire logic shift_carry_bit,
  input wire crf_pkg::crf_bit_op_t bit_op,
  input wire logic [7:0] bit_operand,
  input wire logic [2:0] bit_select,
  // branch condition
  input wire logic [3:0] branch_cond,
  output logic branch_taken
);
  logic [15:0] gpr [0:7];
  logic [15:0] pc;
  logic [7:0] flags;
  crf_pkg::crf_state_t state;
  crf_pkg::crf_state_t next_state;

  // read ports; addresses always take the whole word
  assign rd_a_word = gpr[rd_a_index];
  assign rd_a_byte = rd_a_upper ? gpr[rd_a_index][15:8] : gpr[rd_a_index][7:0];
  assign rd_b_word = gpr[rd_b_index];
  assign reg_addr_word = gpr[rd_a_index];
  assign stack_pointer = gpr[`CRF_SP_INDEX];

  // word accesses ignore the lowest address bit
  assign pc_value = pc;
  assign fetch_addr = {pc[15:1], 1'b0};
  assign word_data_addr = {data_addr_in[15:1], 1'b0};

  // general registers keep their reset-time contents; byte lanes write separately
  always_ff @(posedge clk) begin
    if (reg_wr_en && reg_wr_bytes[1]) begin
      gpr[reg_wr_index][15:8] <= reg_wr_data[15:8];
    end
    if (reg_wr_en && reg_wr_bytes[0]) begin
      gpr[reg_wr_index][7:0] <= reg_wr_data[7:0];
    end
  end

  // reset sequencer: after release the vector word is fetched into the counter
  assign vector_fetch_req = (state == crf_pkg::CRF_ST_VECTOR);
  always_comb begin
    case (state)
      crf_pkg::CRF_ST_RESET: next_state = crf_pkg::CRF_ST_VECTOR;
      crf_pkg::CRF_ST_VECTOR: next_state = vector_word_valid ? crf_pkg::CRF_ST_RUN
                                                             : crf_pkg::CRF_ST_VECTOR;
      crf_pkg::CRF_ST_RUN: next_state = crf_pkg::CRF_ST_RUN;
      default: next_state = crf_pkg::CRF_ST_RESET;
    endcase
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= crf_pkg::CRF_ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // program counter: vector load wins, then jumps, then word advance
  logic [15:0] next_pc;
  assign next_pc = (state == crf_pkg::CRF_ST_VECTOR && vector_word_valid) ? vector_word
                 : (state != crf_pkg::CRF_ST_RUN) ? pc
                 : pc_load ? pc_load_value
                 : pc_advance ? {pc[15:1] + 15'h0001, 1'b0}
                 : pc;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pc <= `CRF_RESET_VECTOR;
    end else begin
      pc <= next_pc;
    end
  end

  // arithmetic: carries at bits 3, 7, 11 and 15 come from split sums
  logic is_sub;
  logic is_word;
  logic cin;
  logic [15:0] opb;
  logic [4:0] lo_nib;
  logic [8:0] byte_sum;
  logic [12:0] w12_sum;
  logic [16:0] word_sum;
  assign is_sub = alu_op inside {crf_pkg::CRF_OP_SUB_B, crf_pkg::CRF_OP_SUBX_B,
                                 crf_pkg::CRF_OP_CMP_B, crf_pkg::CRF_OP_BYTE_NEGATE,
                                 crf_pkg::CRF_OP_SUB_W, crf_pkg::CRF_OP_CMP_W};
  assign is_word = alu_op inside {crf_pkg::CRF_OP_ADD_W, crf_pkg::CRF_OP_SUB_W,
                                  crf_pkg::CRF_OP_CMP_W, crf_pkg::CRF_OP_MOVE_W};
  // borrow convention: subtract adds the complement, carry-out inverted
  assign cin = (alu_op == crf_pkg::CRF_OP_ADDX_B) ? flags[`CRF_BIT_CARRY]
             : (alu_op == crf_pkg::CRF_OP_SUBX_B) ? ~flags[`CRF_BIT_CARRY]
             : is_sub;
  logic [15:0] opa;
  assign opa = (alu_op == crf_pkg::CRF_OP_BYTE_NEGATE) ? 16'h0000 : alu_a;
  assign opb = (alu_op == crf_pkg::CRF_OP_BYTE_NEGATE) ? ~alu_a : (is_sub ? ~alu_b : alu_b);
  assign lo_nib = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
  assign byte_sum = {1'b0, opa[7:0]} + {1'b0, opb[7:0]} + {8'h00, cin};
  assign w12_sum = {1'b0, opa[11:0]} + {1'b0, opb[11:0]} + {12'h000, cin};
  assign word_sum = {1'b0, opa} + {1'b0, opb} + {16'h0000, cin};

  // decimal adjust of a packed BCD byte using carry and half-carry
  logic [7:0] bcd_fix;
  logic bcd_carry;
  logic [7:0] bcd_res;
  assign bcd_fix = {(flags[`CRF_BIT_CARRY] || alu_a[7:0] > 8'h99) ? 4'h6 : 4'h0,
                    (flags[`CRF_BIT_HALF] || alu_a[3:0] > 4'h9) ? 4'h6 : 4'h0};
  assign bcd_carry = (alu_op == crf_pkg::CRF_OP_DAA) ?
                     (flags[`CRF_BIT_CARRY] || alu_a[7:0] > 8'h99) : flags[`CRF_BIT_CARRY];
  assign bcd_res = (alu_op == crf_pkg::CRF_OP_DAA) ? alu_a[7:0] + bcd_fix
                 : alu_a[7:0] - {flags[`CRF_BIT_CARRY] ? 4'h6 : 4'h0,
                                 flags[`CRF_BIT_HALF] ? 4'h6 : 4'h0};

  logic is_bcd;
  logic is_arith;
  logic [15:0] res;
  logic res_neg;
  logic res_ovf;
  logic res_carry;
  logic res_half;
  assign is_bcd = alu_op inside {crf_pkg::CRF_OP_DAA, crf_pkg::CRF_OP_DAS};
  assign is_arith = !is_bcd && !(alu_op inside {crf_pkg::CRF_OP_NONE,
                    crf_pkg::CRF_OP_LOGIC_B, crf_pkg::CRF_OP_MOVE_W});
  assign res = is_bcd ? {8'h00, bcd_res}
             : (alu_op == crf_pkg::CRF_OP_LOGIC_B) ? {8'h00, alu_a[7:0]}
             : (alu_op == crf_pkg::CRF_OP_MOVE_W) ? alu_a
             : is_word ? word_sum[15:0] : {8'h00, byte_sum[7:0]};
  assign alu_result = res;
  assign res_neg = is_word ? res[15] : res[7];
  assign res_half = is_word ? (w12_sum[12] ^ is_sub) : (lo_nib[4] ^ is_sub);
  assign res_carry = is_word ? (word_sum[16] ^ is_sub) : (byte_sum[8] ^ is_sub);
  // signed overflow: like-signed operands giving a result of the other sign
  assign res_ovf = is_word ? (opa[15] == opb[15]) && (res[15] != opa[15])
                           : (opa[7] == opb[7]) && (res[7] != opa[7]);

  // bit accumulator source: one bit of the byte operand
  logic sel_bit;
  logic next_acc;
  assign sel_bit = bit_operand[bit_select];
  assign next_acc = (bit_op == crf_pkg::CRF_BIT_LOAD) ? sel_bit
                  : (bit_op == crf_pkg::CRF_BIT_ILOAD) ? ~sel_bit
                  : (bit_op == crf_pkg::CRF_BIT_AND) ? flags[`CRF_BIT_CARRY] & sel_bit
                  : (bit_op == crf_pkg::CRF_BIT_OR) ? flags[`CRF_BIT_CARRY] | sel_bit
                  : flags[`CRF_BIT_CARRY] ^ sel_bit;

  // flag register next value; untouched bits keep their value
  logic [7:0] next_flags;
  always_comb begin
    next_flags = flags;
    case (flag_cmd)
      crf_pkg::CRF_FC_LOAD: next_flags = flag_cmd_data[7:0];
      crf_pkg::CRF_FC_AND: next_flags = flags & flag_cmd_data[7:0];
      crf_pkg::CRF_FC_OR: next_flags = flags | flag_cmd_data[7:0];
      crf_pkg::CRF_FC_XOR: next_flags = flags ^ flag_cmd_data[7:0];
      crf_pkg::CRF_FC_POP: next_flags = flag_cmd_data[15:8];
      default: next_flags = flags;
    endcase
    // results never reach bits 6 and 4
    if (alu_op != crf_pkg::CRF_OP_NONE) begin
      next_flags[`CRF_BIT_NEG] = res_neg;
      next_flags[`CRF_BIT_ZERO] = is_word ? (res == 16'h0000) : (res[7:0] == 8'h00);
      next_flags[`CRF_BIT_OVF] = is_arith ? res_ovf : 1'b0;
      if (is_arith) begin
        next_flags[`CRF_BIT_HALF] = res_half;
        next_flags[`CRF_BIT_CARRY] = res_carry;
      end
      if (is_bcd) begin
        next_flags[`CRF_BIT_CARRY] = bcd_carry;
      end
    end
    if (shift_carry_en) begin
      next_flags[`CRF_BIT_CARRY] = shift_carry_bit;
    end
    if (bit_op != crf_pkg::CRF_BIT_NONE) begin
      next_flags[`CRF_BIT_CARRY] = next_acc;
    end
    // exception entry masks interrupts over any software write
    if (exception_entry) begin
      next_flags[`CRF_BIT_IMASK] = 1'b1;
    end
  end

  // only the mask bit has a defined reset value; others start at zero here
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags <= `CRF_FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  assign condition_flag_register = flags;
  assign interrupt_masked = flags[`CRF_BIT_IMASK];
  assign flag_push_word = {flags, flags};

  // branch conditions read only N, Z, V and C
  logic cn;
  logic cz;
  logic cv;
  logic cc;
  logic cond_raw;
  assign cn = flags[`CRF_BIT_NEG];
  assign cz = flags[`CRF_BIT_ZERO];
  assign cv = flags[`CRF_BIT_OVF];
  assign cc = flags[`CRF_BIT_CARRY];
  always_comb begin
    case (branch_cond[3:1])
      3'h0: cond_raw = 1'b1;
      3'h1: cond_raw = ~(cc | cz);
      3'h2: cond_raw = ~cc;
      3'h3: cond_raw = ~cz;
      3'h4: cond_raw = ~cv;
      3'h5: cond_raw = ~cn;
      3'h6: cond_raw = ~(cn ^ cv);
      3'h7: cond_raw = ~(cz | (cn ^ cv));
      default: cond_raw = 1'b1;
    endcase
  end
  assign branch_taken = cond_raw ^ branch_cond[0];

  // checks
  sequence s_vec_arrives;
    vector_fetch_req && vector_word_valid;
  endsequence
  a_vector_loads_pc: assert property (@(posedge clk) disable iff (!rstn)
    s_vec_arrives |=> pc == $past(vector_word)) else $error("pc not loaded from vector");
  a_fetch_even_addr: assert property (@(posedge clk) disable iff (!rstn)
    fetch_addr[0] == 1'b0 && fetch_addr[15:1] == pc[15:1]) else $error("fetch address odd");
  a_data_word_align: assert property (@(posedge clk) disable iff (!rstn)
    word_data_addr == (data_addr_in & 16'hFFFE)) else $error("word address not aligned");
  a_exc_sets_mask: assert property (@(posedge clk) disable iff (!rstn)
    exception_entry |=> interrupt_masked) else $error("mask not set on exception");
  a_user_bits_hold: assert property (@(posedge clk) disable iff (!rstn)
    flag_cmd == crf_pkg::CRF_FC_NONE |=> $stable(flags[6]) && $stable(flags[4]))
    else $error("user bits changed");
  a_push_twin_bytes: assert property (@(posedge clk) disable iff (!rstn)
    flag_push_word[15:8] == flag_push_word[7:0] && flag_push_word[7:0] == flags)
    else $error("push word halves differ");
  a_zero_flag_set: assert property (@(posedge clk) disable iff (!rstn)
    alu_op == crf_pkg::CRF_OP_ADD_B && flag_cmd == crf_pkg::CRF_FC_NONE && !shift_carry_en
    && bit_op == crf_pkg::CRF_BIT_NONE |=> flags[2] == (($past(alu_a[7:0]) + $past(alu_b[7:0]))
    == 8'h00)) else $error("zero flag wrong");
  a_byte_half_carry: assert property (@(posedge clk) disable iff (!rstn)
    alu_op == crf_pkg::CRF_OP_ADD_B && flag_cmd == crf_pkg::CRF_FC_NONE |=>
    flags[5] == ((({1'b0, $past(alu_a[3:0])} + {1'b0, $past(alu_b[3:0])}) > 5'h0F)))
    else $error("half carry wrong");
  a_pop_upper_byte: assert property (@(posedge clk) disable iff (!rstn)
    flag_cmd == crf_pkg::CRF_FC_POP && alu_op == crf_pkg::CRF_OP_NONE && !exception_entry
    && !shift_carry_en && bit_op == crf_pkg::CRF_BIT_NONE |=> flags == $past(flag_cmd_data[15:8]))
    else $error("pop did not use upper byte");
endmodule

/* testbench/crf_exec_model.sv */
// datapath side of the register file: answers the reset vector fetch
// assumes the register file raises vector_fetch_req after reset release
`timescale 1ns/1ps
module crf_exec_model #(
  parameter logic [15:0] VEC = 16'h2345,
  parameter int DELAY = 3
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic vector_fetch_req,
  output logic vector_word_valid,
  output logic [15:0] vector_word
);
  logic [7:0] wait_cnt;
  // answer after a latency; outside the answer the word churns so no stale value passes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_cnt <= 8'h00;
      vector_word_valid <= 1'b0;
      vector_word <= ~VEC;
    end else if (vector_fetch_req && !vector_word_valid && wait_cnt == DELAY[7:0]) begin
      vector_word_valid <= 1'b1;
      vector_word <= VEC;
    end else begin
      wait_cnt <= vector_fetch_req ? wait_cnt + 8'h01 : 8'h00;
      vector_word_valid <= 1'b0;
      vector_word <= {vector_word[14:0], ~vector_word[15]};
    end
  end
endmodule

/* testbench/crf_regfile_tb.sv */
// self-checking bench for the core register file and flags
// assumes crf_exec_model answers the vector fetch; a queue pairs notes and results
`timescale 1ns/1ps
module crf_regfile_tb;
  localparam logic [15:0] VEC = 16'h2345;
  logic clk, rstn, reg_wr_en, rd_a_upper, pc_load, pc_advance, vector_word_valid;
  logic exception_entry, shift_carry_en, shift_carry_bit, branch_taken;
  logic interrupt_masked, vector_fetch_req;
  logic [1:0] reg_wr_bytes;
  logic [2:0] reg_wr_index, rd_a_index, rd_b_index, bit_select;
  logic [3:0] branch_cond;
  logic [7:0] rd_a_byte, condition_flag_register, bit_operand;
  logic [15:0] reg_wr_data, rd_a_word, rd_b_word, reg_addr_word, stack_pointer;
  logic [15:0] pc_value, fetch_addr, data_addr_in, word_data_addr, vector_word;
  logic [15:0] flag_push_word, alu_a, alu_b, alu_result, rnd, pc_load_value, flag_cmd_data;
  crf_pkg::crf_flag_cmd_t flag_cmd;
  crf_pkg::crf_alu_op_t alu_op;
  crf_pkg::crf_bit_op_t bit_op;
  int bad_count = 0;
  int tests_run = 0;
  logic [19:0] notes[$];
  logic [19:0] n;
  logic [15:0] img[8];
  string nm[14] = '{"rd_a_word", "rd_a_byte", "flags", "pc_value", "fetch_addr",
    "word_data_addr", "flag_push_word", "branch_taken", "stack_pointer", "reg_addr_word",
    "interrupt_masked", "vector_fetch_req", "rd_b_word", "alu_result"};

  crf_regfile dut (.clk, .rstn, .reg_wr_en, .reg_wr_bytes, .reg_wr_index, .reg_wr_data,
    .rd_a_index, .rd_b_index, .rd_a_word, .rd_a_byte, .rd_a_upper, .rd_b_word,
    .reg_addr_word, .stack_pointer, .pc_load, .pc_load_value, .pc_advance, .pc_value,
    .fetch_addr, .data_addr_in, .word_data_addr, .vector_fetch_req, .vector_word_valid,
    .vector_word, .flag_cmd, .flag_cmd_data, .condition_flag_register, .flag_push_word,
    .exception_entry, .interrupt_masked, .alu_op, .alu_a, .alu_b, .alu_result,
    .shift_carry_en, .shift_carry_bit, .bit_op, .bit_operand, .bit_select, .branch_cond,
    .branch_taken);
  crf_exec_model #(.VEC(VEC), .DELAY(3)) mem (.clk, .rstn, .vector_fetch_req,
    .vector_word_valid, .vector_word);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [15:0] seen(input logic [3:0] k);
    case (k)
      0: return rd_a_word;
      1: return {8'h00, rd_a_byte};
      2: return {8'h00, condition_flag_register};
      3: return pc_value;
      4: return fetch_addr;
      5: return word_data_addr;
      6: return flag_push_word;
      7: return {15'h0000, branch_taken};
      8: return stack_pointer;
      9: return reg_addr_word;
      10: return {15'h0000, interrupt_masked};
      11: return {15'h0000, vector_fetch_req};
      12: return rd_b_word;
      default: return alu_result;
    endcase
  endfunction

  // results are settled by the falling edge, so every note is judged there
  always @(negedge clk) begin
    while (notes.size() > 0) begin
      n = notes.pop_front();
      tests_run++;
      if (seen(n[19:16]) !== n[15:0]) begin
        bad_count++;
        $display("[FAIL] %s expected %h seen %h", nm[n[19:16]], n[15:0], seen(n[19:16]));
      end
    end
  end

  task automatic note(input logic [3:0] k, input logic [15:0] v);
    notes.push_back({k, v});
  endtask

  task automatic wr(input logic [2:0] i, input logic [1:0] b, input logic [15:0] d);
    @(posedge clk);
    {reg_wr_en, reg_wr_bytes, reg_wr_index, reg_wr_data} <= {1'b1, b, i, d};
    @(posedge clk);
    reg_wr_en <= 1'b0;
  endtask

  task automatic fcmd(input crf_pkg::crf_flag_cmd_t c, input logic [15:0] d);
    @(posedge clk);
    flag_cmd <= c;
    flag_cmd_data <= d;
    @(posedge clk);
    flag_cmd <= crf_pkg::CRF_FC_NONE;
  endtask

  // user bits preloaded so any result that touches them shows up
  // the result is judged while the operation is still applied, the flags one edge later
  task automatic alu_chk(input crf_pkg::crf_alu_op_t op, input logic [15:0] a, b, e, r);
    fcmd(crf_pkg::CRF_FC_LOAD, 16'h0050);
    @(posedge clk);
    alu_op <= op;
    {alu_a, alu_b} <= {a, b};
    note(13, r);
    @(posedge clk);
    alu_op <= crf_pkg::CRF_OP_NONE;
    note(2, e);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // hang guard sized well above the roughly 150 cycles the tests need
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    end_sim();
  end

  initial begin
    {rstn, reg_wr_en, rd_a_upper, pc_load, pc_advance, exception_entry} = '0;
    {shift_carry_en, shift_carry_bit, reg_wr_bytes, reg_wr_index, rd_a_index} = '0;
    {rd_b_index, bit_select, branch_cond, bit_operand, reg_wr_data} = '0;
    {pc_load_value, data_addr_in, flag_cmd_data, alu_a, alu_b} = '0;
    flag_cmd = crf_pkg::CRF_FC_NONE;
    alu_op = crf_pkg::CRF_OP_NONE;
    bit_op = crf_pkg::CRF_BIT_NONE;
    rnd = 16'h0053;
    repeat (2) @(posedge clk);
    note(2, 16'h0080);
    note(3, 16'h0000);
    note(11, 16'h0000);
    @(posedge clk);
    rstn <= 1'b1;
    repeat (30) begin
      @(posedge clk);
      if (pc_value === VEC) break;
    end
    note(3, VEC);
    note(4, VEC & 16'hFFFE);
    note(11, 16'h0000);
    $display("test reset vector done");
    // stack pointer first, as word writes only
    for (int i = 7; i >= 0; i--) begin
      rnd = lfsr(rnd);
      img[i] = rnd;
      wr(3'(i), 2'b11, rnd);
    end
    rnd = lfsr(rnd);
    img[3][15:8] = rnd[7:0];
    wr(3'h3, 2'b10, {rnd[7:0], ~rnd[7:0]});
    img[5][7:0] = rnd[15:8];
    wr(3'h5, 2'b01, {~rnd[15:8], rnd[15:8]});
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      {rd_a_index, rd_b_index, rd_a_upper} <= {3'(i), 3'(7 - i), i[0]};
      note(0, img[i]);
      note(1, {8'h00, i[0] ? img[i][15:8] : img[i][7:0]});
      note(9, img[i]);
      note(12, img[7 - i]);
    end
    note(8, img[7]);
    $display("test registers done");
    fcmd(crf_pkg::CRF_FC_LOAD, 16'h00FF);
    note(2, 16'h00FF);
    fcmd(crf_pkg::CRF_FC_AND, 16'h003C);
    note(2, 16'h003C);
    fcmd(crf_pkg::CRF_FC_OR, 16'h0041);
    note(2, 16'h007D);
    fcmd(crf_pkg::CRF_FC_XOR, 16'h00FF);
    note(2, 16'h0082);
    fcmd(crf_pkg::CRF_FC_POP, 16'hA55A);
    note(2, 16'h00A5);
    note(6, 16'hA5A5);
    fcmd(crf_pkg::CRF_FC_LOAD, 16'h0000);
    @(posedge clk);
    exception_entry <= 1'b1;
    @(posedge clk);
    exception_entry <= 1'b0;
    note(2, 16'h0080);
    note(10, 16'h0001);
    $display("test flag access done");
    alu_chk(crf_pkg::CRF_OP_ADD_B, 16'h0008, 16'h0008, 16'h0070,
      16'h0010);
    alu_chk(crf_pkg::CRF_OP_ADD_B, 16'h0080, 16'h0080, 16'h0057,
      16'h0000);
    alu_chk(crf_pkg::CRF_OP_SUB_B, 16'h0010, 16'h0001, 16'h0070,
      16'h000F);
    alu_chk(crf_pkg::CRF_OP_BYTE_NEGATE, 16'h0001, 16'h0000, 16'h0079,
      16'h00FF);
    alu_chk(crf_pkg::CRF_OP_ADD_W, 16'h0800, 16'h0800, 16'h0070,
      16'h1000);
    alu_chk(crf_pkg::CRF_OP_ADD_W, 16'h7FFF, 16'h0001, 16'h007A,
      16'h8000);
    alu_chk(crf_pkg::CRF_OP_CMP_W, 16'h1000, 16'h0001, 16'h0070,
      16'h0FFF);
    alu_chk(crf_pkg::CRF_OP_DAA, 16'h009A, 16'h0000, 16'h0055,
      16'h0000);
    alu_chk(crf_pkg::CRF_OP_MOVE_W, 16'h8000, 16'h0000, 16'h0058,
      16'h8000);
    $display("test arithmetic flags done");
    fcmd(crf_pkg::CRF_FC_LOAD, 16'h0000);
    rnd = lfsr(rnd);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      bit_op <= crf_pkg::CRF_BIT_LOAD;
      {bit_operand, bit_select} <= {rnd[7:0], 3'(i)};
      @(posedge clk);
      bit_op <= crf_pkg::CRF_BIT_NONE;
      note(2, {15'h0000, rnd[i]});
    end
    @(posedge clk);
    {shift_carry_en, shift_carry_bit} <= {1'b1, ~rnd[7]};
    @(posedge clk);
    shift_carry_en <= 1'b0;
    note(2, {15'h0000, ~rnd[7]});
    $display("test carry accumulator done");
    // user, mask and half-carry bits must not sway any condition
    for (int f = 0; f < 2; f++) begin
      fcmd(crf_pkg::CRF_FC_LOAD, f ? 16'h00F0 : 16'h000F);
      for (int c = 0; c < 16; c++) begin
        @(posedge clk);
        branch_cond <= {3'(c / 2), c[0]};
        note(7, {15'h0000, c[0] ^ ((c < 2) || (c / 2 == 6) || (f == 1))});
      end
    end
    $display("test branch done");
    @(posedge clk);
    {pc_load, pc_load_value} <= {1'b1, 16'h1001};
    @(posedge clk);
    {pc_load, pc_advance} <= 2'b01;
    note(4, 16'h1000);
    rnd = lfsr(rnd);
    @(posedge clk);
    pc_advance <= 1'b0;
    data_addr_in <= rnd | 16'h0001;
    note(4, 16'h1002);
    note(5, rnd & 16'hFFFE);
    $display("test addressing done");
    repeat (2) @(posedge clk);
    end_sim();
  end
endmodule
